// ---- src_pkg.sv ----
// Shared constants and types for the sensor reset and mode control block.
package src_pkg;

	// ----------------------------------------------------------------
	// Clock and power-on timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 25;
	localparam int POR_TIME_NS = 100000;
	// Longest time, so the count rounds down.
	localparam int POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
	localparam int POR_CNT_W = 12;
	localparam logic [POR_CNT_W-1:0] POR_CNT_LAST = POR_CNT_W'(POR_CYC - 1);
	localparam logic [POR_CNT_W-1:0] POR_CNT_RST = 12'h000;

	// ----------------------------------------------------------------
	// Bus identity and mode field
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR = 7'h64;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 2;

	typedef enum logic [MODE_W-1:0] {
		MODE_STANDBY = 2'h0,
		MODE_CONT = 2'h1,
		MODE_SINGLE = 2'h2
	} src_mode_t;

	localparam src_mode_t MODE_RST = MODE_STANDBY;

endpackage

// ---- src_por_timer.sv ----
// Power-on reset timer: holds the core until the supply is good and settled.
`timescale 1ns/10ps
`default_nettype none
module src_por_timer (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic supply_ok_i,
	output logic por_done_o
);
	import src_pkg::*;

	logic [POR_CNT_W-1:0] cnt_r;
	logic [POR_CNT_W-1:0] cnt_nxt;
	logic done_r;
	logic done_nxt;

	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = done_r;
		if (!supply_ok_i) begin
			// A supply dip restarts the whole settle time.
			cnt_nxt = POR_CNT_RST;
			done_nxt = 1'b0;
		end else if (!done_r) begin
			if (cnt_r == POR_CNT_LAST) begin
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + 12'h001;
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			cnt_r <= POR_CNT_RST;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign por_done_o = done_r;

endmodule
`default_nettype wire

// ---- src_ctrl.sv ----
// Sensor reset and operating-mode control, top level.
`timescale 1ns/10ps
`default_nettype none
module src_ctrl (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic supply_ok_i,
	input wire logic addr_valid_i,
	input wire logic [6:0] addr_byte_i,
	input wire logic soft_rst_wr_i,
	input wire logic ack_done_i,
	input wire logic mode_wr_i,
	input wire logic [src_pkg::MODE_W-1:0] mode_wdata_i,
	input wire logic meas_done_i,
	input wire logic irq_event_i,
	output logic core_rst_o,
	output logic i2c_en_o,
	output logic addr_match_o,
	output logic [src_pkg::MODE_W-1:0] mode_o,
	output logic analog_pwr_o,
	output logic interrupt_request_out_o,
	output logic interrupt_request_out_oe_o
);
	import src_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic mode_legal(input logic [MODE_W-1:0] m);
		mode_legal = (m == MODE_STANDBY) || (m == MODE_CONT) || (m == MODE_SINGLE);
	endfunction

	logic por_done;

	src_por_timer u_por (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.supply_ok_i(supply_ok_i),
		.por_done_o(por_done)
	);

	// ----------------------------------------------------------------
	// Reset sequencing
	// ----------------------------------------------------------------
	typedef enum logic {ST_POR, ST_RUN} src_state_t;

	src_state_t state_r;
	src_state_t state_nxt;
	logic srst_pend_r;
	logic srst_pend_nxt;
	logic core_rst_r;
	logic core_rst_nxt;
	logic i2c_en_r;
	logic i2c_en_nxt;
	logic srst_fire;

	// The reset write stays pending until its acknowledge bit has gone out,
	// so the bus engine is never reset in the middle of its own answer.
	assign srst_fire = (srst_pend_r || soft_rst_wr_i) && ack_done_i;

	always_comb begin
		state_nxt = state_r;
		srst_pend_nxt = srst_pend_r;
		unique case (state_r)
			ST_POR: begin
				srst_pend_nxt = 1'b0;
				if (por_done && supply_ok_i) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!supply_ok_i || !por_done) begin
					state_nxt = ST_POR;
					srst_pend_nxt = 1'b0;
				end else if (srst_fire) begin
					srst_pend_nxt = 1'b0;
				end else if (soft_rst_wr_i) begin
					srst_pend_nxt = 1'b1;
				end
			end
		endcase
		core_rst_nxt = (state_nxt == ST_POR) || (state_r == ST_RUN && srst_fire);
		// The bus stays enabled across a software reset; only power loss stops it.
		i2c_en_nxt = (state_nxt == ST_RUN);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_r <= ST_POR;
			srst_pend_r <= 1'b0;
			core_rst_r <= 1'b1;
			i2c_en_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			srst_pend_r <= srst_pend_nxt;
			core_rst_r <= core_rst_nxt;
			i2c_en_r <= i2c_en_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic addr_match_r;
	logic addr_match_nxt;

	always_comb begin
		// No answer before the power-on sequence ends protects a too-early host.
		addr_match_nxt = addr_valid_i && i2c_en_r && (addr_byte_i == DEV_ADDR);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			addr_match_r <= 1'b0;
		end else begin
			addr_match_r <= addr_match_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Mode field, power and interrupt pin
	// ----------------------------------------------------------------
	logic [MODE_W-1:0] mode_r;
	logic [MODE_W-1:0] mode_nxt;
	logic analog_r;
	logic analog_nxt;
	logic irq_oe_r;
	logic irq_oe_nxt;

	always_comb begin
		mode_nxt = mode_r;
		if (core_rst_nxt) begin
			mode_nxt = MODE_RST;
		end else if (mode_wr_i && !core_rst_r && mode_legal(mode_wdata_i)) begin
			// A host write beats the self-clear; code 11 is ignored, and so is a
			// write that lands while the reset pulse still stands.
			mode_nxt = mode_wdata_i;
		end else if (mode_r == MODE_SINGLE && meas_done_i) begin
			mode_nxt = MODE_STANDBY;
		end
		analog_nxt = (mode_nxt != MODE_STANDBY);
		irq_oe_nxt = irq_event_i && (mode_nxt != MODE_STANDBY);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mode_r <= MODE_RST;
			analog_r <= 1'b0;
			irq_oe_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			analog_r <= analog_nxt;
			irq_oe_r <= irq_oe_nxt;
		end
	end

	assign core_rst_o = core_rst_r;
	assign i2c_en_o = i2c_en_r;
	assign addr_match_o = addr_match_r;
	assign mode_o = mode_r;
	assign analog_pwr_o = analog_r;
	// Open drain: the pin only ever pulls low; the pull-up makes it high.
	assign interrupt_request_out_o = 1'b0;
	assign interrupt_request_out_oe_o = irq_oe_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_srst_fire;
		state_r == ST_RUN && supply_ok_i && por_done && srst_fire;
	endsequence

	sequence s_mode_wr;
		mode_wr_i && mode_legal(mode_wdata_i) && !core_rst_nxt && !core_rst_r;
	endsequence

	a_supply_low_rst: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!supply_ok_i |=> core_rst_o && !i2c_en_o)
		else $error("core not held in reset while supply low");

	a_por_standby: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$fell(core_rst_o) |-> mode_o == MODE_STANDBY && !analog_pwr_o && !interrupt_request_out_oe_o)
		else $error("reset release not in standby");

	a_srst_effect: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_srst_fire |=> core_rst_o ##1 !core_rst_o && mode_o == MODE_STANDBY)
		else $error("software reset did not return to power-on state");

	a_srst_wait_ack: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		state_r == ST_RUN && supply_ok_i && por_done && soft_rst_wr_i && !ack_done_i
		|=> !core_rst_o && srst_pend_r)
		else $error("software reset acted before acknowledge");

	a_addr_match: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		addr_valid_i && i2c_en_o |=> addr_match_o == ($past(addr_byte_i) == DEV_ADDR))
		else $error("target address decode wrong");

	a_mode_legal: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		mode_legal(mode_o))
		else $error("illegal mode code held");

	a_mode_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s_mode_wr |=> mode_o == $past(mode_wdata_i))
		else $error("mode write not applied");

	a_single_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		mode_o == MODE_SINGLE && meas_done_i && !mode_wr_i && !core_rst_nxt
		|=> mode_o == MODE_STANDBY && !analog_pwr_o)
		else $error("single shot did not return to standby");

	a_standby_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		mode_o == MODE_STANDBY |-> !interrupt_request_out_oe_o && !analog_pwr_o)
		else $error("standby left interrupt or analog active");

endmodule
`default_nettype wire

// ---- src_host_model.sv ----
// Host side model: pull-up on the interrupt line and power-on gating of bus access.
`timescale 1ns/10ps
`default_nettype none
module src_host_model (
	input wire logic od_i,
	input wire logic oe_i,
	input wire logic i2c_en_i,
	output logic pin_o,
	output logic host_ok_o
);
	// ----------------------------------------------------------------
	// Pin level and access gating
	// ----------------------------------------------------------------
	// The external pull-up makes a released line read high.
	assign pin_o = oe_i ? od_i : 1'b1;
	// The host holds off every request until the bus engine is enabled.
	assign host_ok_o = i2c_en_i;
endmodule
`default_nettype wire

// ---- tb_sensor_reset_and_mode_control.sv ----
// Self-checking testbench for the sensor reset and mode control block.
`timescale 1ns/10ps
`default_nettype none
module tb_sensor_reset_and_mode_control;
	import src_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic supply_ok_i = 1'b1;
	logic av = 1'b0, mw = 1'b0, srw = 1'b0, ackd = 1'b0, md = 1'b0, irq = 1'b0;
	logic [6:0] ab = 7'h00;
	logic [1:0] wd = 2'h0;
	logic core_rst, i2c_en, match, pwr, od, oe, pin, host_ok;
	logic [1:0] mode;
	int error_cnt = 0;
	int total_checks = 0;
	// Rows: address, mode code, then expected match, mode and analog power.
	logic [12:0] rows [5] = '{{7'h64, 2'h1, 4'hB}, {7'h65, 2'h3, 4'h3},
		{7'h64, 2'h2, 4'hD}, {7'h24, 2'h0, 4'h0}, {7'h64, 2'h1, 4'hB}};

	src_ctrl src_ctrl_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.supply_ok_i(supply_ok_i), .addr_valid_i(av), .addr_byte_i(ab),
		.soft_rst_wr_i(srw), .ack_done_i(ackd), .mode_wr_i(mw), .mode_wdata_i(wd),
		.meas_done_i(md), .irq_event_i(irq), .core_rst_o(core_rst), .i2c_en_o(i2c_en),
		.addr_match_o(match), .mode_o(mode), .analog_pwr_o(pwr),
		.interrupt_request_out_o(od), .interrupt_request_out_oe_o(oe));
	src_host_model src_host_model_i (.od_i(od), .oe_i(oe), .i2c_en_i(i2c_en),
		.pin_o(pin), .host_ok_o(host_ok));

	initial begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	task report_and_stop();
		if (error_cnt == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Compares reset, enable, match, mode, power and pin level in one go.
	task chk(input logic [6:0] e);
		total_checks++;
		if ({core_rst, i2c_en, match, mode, pwr, pin} !== e) begin
			$display("MISMATCH outputs expected %b seen %b", e,
				{core_rst, i2c_en, match, mode, pwr, pin});
			error_cnt++;
		end
	endtask

	// Strobes {addr, mode, soft reset, ack, meas done} for one cycle, set at the falling edge.
	task put(input logic [4:0] s);
		{av, mw, srw, ackd, md} = s;
		@(negedge ref_clk_i);
	endtask

	// Waits for the host to be allowed on the bus; early or never is an error.
	task wait_en(input int exp_k);
		int k;
		k = 0;
		while (host_ok !== 1'b1 && k < 5000) begin
			@(negedge ref_clk_i);
			k++;
		end
		total_checks++;
		if (k != exp_k) begin
			$display("MISMATCH power_on_cycles expected %0d seen %0d", exp_k, k);
			error_cnt++;
			report_and_stop();
		end
	endtask

	initial begin
		repeat (2) @(negedge ref_clk_i);
		chk(7'b1000001);
		sys_rst_i = 1'b0;
		wait_en(POR_CYC + 1);
		chk(7'b0100001);
		for (int i = 0; i < 5; i++) begin
			{ab, wd} = rows[i][12:4];
			put(5'h18);
			chk({2'b01, rows[i][3:0], 1'b1});
		end
		wd = 2'h2;
		put(5'h08);
		chk(7'b0101011);
		put(5'h01);
		put(5'h00);
		chk(7'b0100001);
		wd = 2'h1;
		irq = 1'b1;
		put(5'h08);
		chk(7'b0100110);
		wd = 2'h0;
		put(5'h08);
		chk(7'b0100001);
		put(5'h00);
		chk(7'b0100001);
		irq = 1'b0;
		wd = 2'h1;
		put(5'h08);
		put(5'h02);
		chk(7'b0100111);
		put(5'h04);
		put(5'h00);
		chk(7'b0100111);
		put(5'h02);
		chk(7'b1100001);
		put(5'h00);
		chk(7'b0100001);
		put(5'h06);
		chk(7'b1100001);
		put(5'h08);
		chk(7'b0100001);
		supply_ok_i = 1'b0;
		put(5'h08);
		chk(7'b1000001);
		supply_ok_i = 1'b1;
		put(5'h00);
		wait_en(POR_CYC);
		chk(7'b0100001);
		report_and_stop();
	end
endmodule
`default_nettype wire
